// file: verilog/apr_pkg.sv
package apr_pkg;
    localparam int NUM_PINS      = 20;
    localparam int NUM_SPORTS    = 8;
    localparam int NUM_MISCA     = 6;
    localparam int NUM_MISCB     = 2;
    localparam int NUM_CKG       = 4;
    localparam int NUM_SRC       = 4;
    localparam int PIN_SEL_W     = 7;
    localparam int MISC_SEL_W    = 5;
    localparam int EN_SEL_W      = 6;
    localparam int SPORT_EN_W    = 4 * NUM_SPORTS;

    // pin source codes
    localparam logic [6:0] PS_PB_LAST     = 7'h13;
    localparam logic [6:0] PS_SP_DATA     = 7'h14;
    localparam logic [6:0] PS_SP_DATA_END = 7'h1f;
    localparam logic [6:0] PS_SP_CLK      = 7'h20;
    localparam logic [6:0] PS_SP_CLK_END  = 7'h25;
    localparam logic [6:0] PS_SP_FS       = 7'h26;
    localparam logic [6:0] PS_SP_FS_END   = 7'h2b;
    localparam logic [6:0] PS_SP67_DATA   = 7'h2c;
    localparam logic [6:0] PS_SP67_DEND   = 7'h2f;
    localparam logic [6:0] PS_PP_STROBE   = 7'h30;
    localparam logic [6:0] PS_TX_BLKST    = 7'h31;
    localparam logic [6:0] PS_SP6_CLK     = 7'h34;
    localparam logic [6:0] PS_SP7_CLK     = 7'h35;
    localparam logic [6:0] PS_SP6_FS      = 7'h36;
    localparam logic [6:0] PS_SP7_FS      = 7'h37;
    localparam logic [6:0] PS_CKG_CLK_AB  = 7'h38;
    localparam logic [6:0] PS_CKG_FS_AB   = 7'h3a;
    localparam logic [6:0] PS_RSV_3C      = 7'h3c;
    localparam logic [6:0] PS_SRC         = 7'h3d;
    localparam logic [6:0] PS_SRC_END     = 7'h40;
    localparam logic [6:0] PS_RX_DATA     = 7'h41;
    localparam logic [6:0] PS_RX_FS       = 7'h42;
    localparam logic [6:0] PS_RX_CLK      = 7'h43;
    localparam logic [6:0] PS_RX_TDMCLK   = 7'h44;
    localparam logic [6:0] PS_TX_BIPHASE  = 7'h45;
    localparam logic [6:0] PS_TDV         = 7'h46;
    localparam logic [6:0] PS_TDV_END     = 7'h4d;
    localparam logic [6:0] PS_RX_PLL_REF  = 7'h4e;
    localparam logic [6:0] PS_RX_PLL_FB   = 7'h4f;
    localparam logic [6:0] PS_CKG_CLK_CD  = 7'h50;
    localparam logic [6:0] PS_CKG_FS_CD   = 7'h52;
    localparam logic [6:0] PS_LOW         = 7'h7e;
    localparam logic [6:0] PS_HIGH        = 7'h7f;

    // misc source codes
    localparam logic [4:0] MS_PB_LAST     = 5'h13;
    localparam logic [4:0] MS_SP_FS       = 5'h14;
    localparam logic [4:0] MS_SP_FS_END   = 5'h19;
    localparam logic [4:0] MS_TX_BLKST    = 5'h1a;
    localparam logic [4:0] MS_CKG_FSA     = 5'h1b;
    localparam logic [4:0] MS_CKG_CLKB    = 5'h1c;
    localparam logic [4:0] MS_CKG_FSB     = 5'h1d;
    localparam logic [4:0] MS_LOW         = 5'h1e;
    localparam logic [4:0] MS_HIGH        = 5'h1f;

    // drive-enable source codes
    localparam logic [5:0] ES_LOW         = 6'h00;
    localparam logic [5:0] ES_HIGH        = 6'h01;
    localparam logic [5:0] ES_MISCA       = 6'h02;
    localparam logic [5:0] ES_MISCA_END   = 6'h07;
    localparam logic [5:0] ES_SP_EN       = 6'h08;
    localparam logic [5:0] ES_SP_EN_END   = 6'h19;

    // first misc-a input used as a one-shot trigger (a2..a5 feed generators a..d)
    localparam int MISCA_TRIG_BASE = 2;

    localparam logic [6:0] PIN_SEL_RST  = 7'h7e;
    localparam logic [4:0] MISC_SEL_RST = 5'h1e;
    localparam logic [5:0] EN_SEL_RST   = 6'h00;
endpackage : apr_pkg

// file: verilog/apr_misc_mux.sv
`timescale 1ns/1ns
module apr_misc_mux
    import apr_pkg::*;
(
    input  wire logic [MISC_SEL_W-1:0] sel,
    input  wire logic [NUM_PINS-1:0]   pin_buffer_output,
    input  wire logic [5:0]            serial_port_frame_sync_out,
    input  wire logic                  spdif_tx_block_start,
    input  wire logic                  precision_frame_sync_a_out,
    input  wire logic                  precision_clock_b_out,
    input  wire logic                  precision_frame_sync_b_out,
    output logic                       y
);
    always_comb begin
        y = 1'b0;
        if (sel <= MS_PB_LAST) begin
            y = pin_buffer_output[sel];
        end else if (sel <= MS_SP_FS_END) begin
            y = serial_port_frame_sync_out[3'(sel - MS_SP_FS)];
        end else begin
            case (sel)
                MS_TX_BLKST: y = spdif_tx_block_start;
                MS_CKG_FSA:  y = precision_frame_sync_a_out;
                MS_CKG_CLKB: y = precision_clock_b_out;
                MS_CKG_FSB:  y = precision_frame_sync_b_out;
                MS_HIGH:     y = 1'b1;
                default:     y = 1'b0;
            endcase
        end
    end
endmodule : apr_misc_mux

// file: verilog/apr_enable_mux.sv
`timescale 1ns/1ns
module apr_enable_mux
    import apr_pkg::*;
(
    input  wire logic [EN_SEL_W-1:0]   sel,
    input  wire logic [NUM_MISCA-1:0]  misc_control_a_out,
    input  wire logic [SPORT_EN_W-1:0] serial_port_drive_en,
    output logic                       y
);
    // serial_port_drive_en packs {db,da,fs,clk} per port, port 0 lowest
    always_comb begin
        y = 1'b0;
        if (sel == ES_HIGH) begin
            y = 1'b1;
        end else if (sel >= ES_MISCA && sel <= ES_MISCA_END) begin
            y = misc_control_a_out[3'(sel - ES_MISCA)];
        end else if (sel >= ES_SP_EN && sel <= ES_SP_EN_END) begin
            y = serial_port_drive_en[5'(sel - ES_SP_EN)];
        end
    end
endmodule : apr_enable_mux

// file: verilog/apr_router.sv
`timescale 1ns/1ns
// Notes on behaviour
// - 7-bit pin code; 0x0-0x13 pin buffers, then port 0-5 data, clocks, frame syncs.
// - 0x2c-0x2f ports 6/7 data, 0x30 strobe, 0x31 block start, 0x34-0x37 clk/fs.
// - 0x38-0x3b clock generator a/b clk and fs; 0x3c reserved; 0x3d-0x40 converters.
// - 0x41-0x44 s/pdif receiver data, fs, clock, tdm clock; 0x45 biphase out.
// - 0x46-0x4d transmit-valid of ports 0 to 7 in order.
// - 0x4e receiver pll reference point, 0x4f feedback point.
// - 0x50-0x53 clock generator c/d clk and fs; 0x54-0x7d reserved.
// - 0x7e constant low, 0x7f constant high.
// - misc set a feeds interrupt latch, drive-enable inputs and one-shot triggers.
// - misc set b feeds only the interrupt latch.
// - with one-shot on, misc a2..a5 trigger clock generators a..d.
// - 5-bit misc code; 0x0-0x13 pin buffers, 0x14-0x19 port 0-5 frame syncs.
// - misc 0x1a block start, 0x1b-0x1d generator signals, 0x1e low, 0x1f high.
// - one drive-enable per pin; undriven pin serves as input.
// - 6-bit enable code; 0 low, 1 high, 0x2-0x7 misc a0..a5.
// - enable 0x8-0x19 port enables, four per port: clk, fs, da, db.
// - every pin routable through the 7-bit pin source selector.
module apr_router
    import apr_pkg::*;
(
    input  wire logic                          sys_clk,
    input  wire logic                          resetn,
    input  wire logic [NUM_PINS*PIN_SEL_W-1:0] pin_source_select,
    input  wire logic [NUM_MISCA*MISC_SEL_W-1:0] misc_routing_set_a,
    input  wire logic [NUM_MISCB*MISC_SEL_W-1:0] misc_routing_set_b,
    input  wire logic [NUM_PINS*EN_SEL_W-1:0]  pin_drive_enable_select,
    input  wire logic [NUM_PINS-1:0]           pin_invert,
    input  wire logic [NUM_CKG-1:0]            one_shot_enable,
    input  wire logic [NUM_PINS-1:0]           pin_in,
    input  wire logic [NUM_SPORTS-1:0]         serial_port_data_a_out,
    input  wire logic [NUM_SPORTS-1:0]         serial_port_data_b_out,
    input  wire logic [NUM_SPORTS-1:0]         serial_port_clock_out,
    input  wire logic [NUM_SPORTS-1:0]         serial_port_frame_sync_out,
    input  wire logic [NUM_SPORTS-1:0]         serial_port_tx_valid_out,
    input  wire logic [SPORT_EN_W-1:0]         serial_port_drive_en,
    input  wire logic                          parallel_port_request_strobe,
    input  wire logic                          spdif_tx_block_start,
    input  wire logic                          spdif_tx_biphase_out,
    input  wire logic                          spdif_rx_data_out,
    input  wire logic                          spdif_rx_frame_sync_out,
    input  wire logic                          spdif_rx_clock_out,
    input  wire logic                          spdif_rx_tdm_clock_out,
    input  wire logic                          spdif_rx_pll_reference,
    input  wire logic                          spdif_rx_pll_feedback,
    input  wire logic [NUM_CKG-1:0]            precision_clock_out,
    input  wire logic [NUM_CKG-1:0]            precision_frame_sync_out,
    input  wire logic [NUM_SRC-1:0]            rate_converter_data_out,
    output logic      [NUM_PINS-1:0]           pin_out,
    output logic      [NUM_PINS-1:0]           pin_oe,
    output logic      [NUM_PINS-1:0]           pin_buffer_output,
    output logic      [NUM_MISCA-1:0]          misc_control_a_out,
    output logic      [NUM_MISCB-1:0]          misc_control_b_out,
    output logic      [NUM_CKG-1:0]            one_shot_trigger
);
    import apr_pkg::*;

    logic [NUM_PINS-1:0]  pin_meta_r;
    logic [NUM_PINS-1:0]  pin_sync_r;
    logic [NUM_PINS-1:0]  src_nxt;
    logic [NUM_PINS-1:0]  oe_nxt;
    logic [NUM_PINS-1:0]  pb_nxt;
    logic [NUM_PINS-1:0]  pin_out_r;
    logic [NUM_PINS-1:0]  pin_oe_r;
    logic [NUM_PINS-1:0]  pb_r;
    logic [NUM_MISCA-1:0] misca_nxt;
    logic [NUM_MISCB-1:0] miscb_nxt;
    logic [NUM_MISCA-1:0] misca_r;
    logic [NUM_MISCB-1:0] miscb_r;
    logic [NUM_CKG-1:0]   trig_nxt;
    logic [NUM_CKG-1:0]   trig_r;

    // pin levels arrive from outside; two stages before anything reads them
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pin_meta_r <= '0;
            pin_sync_r <= '0;
        end else begin
            pin_meta_r <= pin_in;
            pin_sync_r <= pin_meta_r;
        end
    end

    // pin buffer output: the driven value while enabled, else the sampled pad.
    // inversion only applies to the pad path, never to our own loop-back.
    always_comb begin
        for (int i = 0; i < NUM_PINS; i++) begin
            if (pin_oe_r[i]) begin
                pb_nxt[i] = pin_out_r[i];
            end else begin
                pb_nxt[i] = pin_sync_r[i] ^ pin_invert[i];
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_PINS; g++) begin : g_pin
            logic [PIN_SEL_W-1:0] s;
            logic                 pick;
            assign s = pin_source_select[g*PIN_SEL_W +: PIN_SEL_W];
            // a local result per pin keeps each process the only writer of its variable
            assign src_nxt[g] = pick;

            always_comb begin
                pick = 1'b0;
                if (s <= PS_PB_LAST) begin
                    pick = pb_r[5'(s)];
                end else if (s <= PS_SP_DATA_END) begin
                    if (s[0]) begin
                        pick = serial_port_data_b_out[3'((s - PS_SP_DATA) >> 1)];
                    end else begin
                        pick = serial_port_data_a_out[3'((s - PS_SP_DATA) >> 1)];
                    end
                end else if (s <= PS_SP_CLK_END) begin
                    pick = serial_port_clock_out[3'(s - PS_SP_CLK)];
                end else if (s <= PS_SP_FS_END) begin
                    pick = serial_port_frame_sync_out[3'(s - PS_SP_FS)];
                end else if (s <= PS_SP67_DEND) begin
                    if (s[0]) begin
                        pick = serial_port_data_b_out[3'(6 + ((s - PS_SP67_DATA) >> 1))];
                    end else begin
                        pick = serial_port_data_a_out[3'(6 + ((s - PS_SP67_DATA) >> 1))];
                    end
                end else if (s >= PS_SRC && s <= PS_SRC_END) begin
                    pick = rate_converter_data_out[2'(s - PS_SRC)];
                end else if (s >= PS_TDV && s <= PS_TDV_END) begin
                    pick = serial_port_tx_valid_out[3'(s - PS_TDV)];
                end else begin
                    case (s)
                        PS_PP_STROBE:         pick = parallel_port_request_strobe;
                        PS_TX_BLKST:          pick = spdif_tx_block_start;
                        PS_SP6_CLK:           pick = serial_port_clock_out[6];
                        PS_SP7_CLK:           pick = serial_port_clock_out[7];
                        PS_SP6_FS:            pick = serial_port_frame_sync_out[6];
                        PS_SP7_FS:            pick = serial_port_frame_sync_out[7];
                        PS_CKG_CLK_AB:        pick = precision_clock_out[0];
                        PS_CKG_CLK_AB + 7'h1: pick = precision_clock_out[1];
                        PS_CKG_FS_AB:         pick = precision_frame_sync_out[0];
                        PS_CKG_FS_AB + 7'h1:  pick = precision_frame_sync_out[1];
                        PS_RSV_3C:            pick = 1'b0;
                        PS_RX_DATA:           pick = spdif_rx_data_out;
                        PS_RX_FS:             pick = spdif_rx_frame_sync_out;
                        PS_RX_CLK:            pick = spdif_rx_clock_out;
                        PS_RX_TDMCLK:         pick = spdif_rx_tdm_clock_out;
                        PS_TX_BIPHASE:        pick = spdif_tx_biphase_out;
                        PS_RX_PLL_REF:        pick = spdif_rx_pll_reference;
                        PS_RX_PLL_FB:         pick = spdif_rx_pll_feedback;
                        PS_CKG_CLK_CD:        pick = precision_clock_out[2];
                        PS_CKG_CLK_CD + 7'h1: pick = precision_clock_out[3];
                        PS_CKG_FS_CD:         pick = precision_frame_sync_out[2];
                        PS_CKG_FS_CD + 7'h1:  pick = precision_frame_sync_out[3];
                        PS_LOW:               pick = 1'b0;
                        PS_HIGH:              pick = 1'b1;
                        default:              pick = 1'b0;
                    endcase
                end
            end

            apr_enable_mux u_en (
                .sel                  (pin_drive_enable_select[g*EN_SEL_W +: EN_SEL_W]),
                .misc_control_a_out   (misca_r),
                .serial_port_drive_en (serial_port_drive_en),
                .y                    (oe_nxt[g])
            );
        end

        for (g = 0; g < NUM_MISCA; g++) begin : g_misca
            apr_misc_mux u_mux (
                .sel                        (misc_routing_set_a[g*MISC_SEL_W +: MISC_SEL_W]),
                .pin_buffer_output          (pb_r),
                .serial_port_frame_sync_out (serial_port_frame_sync_out[5:0]),
                .spdif_tx_block_start       (spdif_tx_block_start),
                .precision_frame_sync_a_out (precision_frame_sync_out[0]),
                .precision_clock_b_out      (precision_clock_out[1]),
                .precision_frame_sync_b_out (precision_frame_sync_out[1]),
                .y                          (misca_nxt[g])
            );
        end

        // set b goes only to the interrupt latch output, nowhere else
        for (g = 0; g < NUM_MISCB; g++) begin : g_miscb
            apr_misc_mux u_mux (
                .sel                        (misc_routing_set_b[g*MISC_SEL_W +: MISC_SEL_W]),
                .pin_buffer_output          (pb_r),
                .serial_port_frame_sync_out (serial_port_frame_sync_out[5:0]),
                .spdif_tx_block_start       (spdif_tx_block_start),
                .precision_frame_sync_a_out (precision_frame_sync_out[0]),
                .precision_clock_b_out      (precision_clock_out[1]),
                .precision_frame_sync_b_out (precision_frame_sync_out[1]),
                .y                          (miscb_nxt[g])
            );
        end
    endgenerate

    always_comb begin
        for (int k = 0; k < NUM_CKG; k++) begin
            trig_nxt[k] = one_shot_enable[k] & misca_nxt[MISCA_TRIG_BASE + k];
        end
    end

    // every output is registered: one cycle of latency from source to pin,
    // traded for glitch-free pins when a select changes
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pin_out_r <= '0;
            pin_oe_r  <= '0;
            pb_r      <= '0;
            misca_r   <= '0;
            miscb_r   <= '0;
            trig_r    <= '0;
        end else begin
            pin_out_r <= src_nxt;
            pin_oe_r  <= oe_nxt;
            pb_r      <= pb_nxt;
            misca_r   <= misca_nxt;
            miscb_r   <= miscb_nxt;
            trig_r    <= trig_nxt;
        end
    end

    assign pin_out            = pin_out_r;
    assign pin_oe             = pin_oe_r;
    assign pin_buffer_output  = pb_r;
    assign misc_control_a_out = misca_r;
    assign misc_control_b_out = miscb_r;
    assign one_shot_trigger   = trig_r;
endmodule : apr_router

// file: sim/apr_far_model.sv
`timescale 1ns/1ns
module apr_far_model
    import apr_pkg::*;
(
    input  wire logic [7:0]          hot,
    input  wire logic                inv,
    input  wire logic [NUM_PINS-1:0] pin_out,
    input  wire logic [NUM_PINS-1:0] pin_oe,
    output logic      [92:0]         src,
    output logic      [NUM_PINS-1:0] pin_in
);
    // one source differs from all others, so a wrong selection shows up
    always_comb begin
        for (int i = 0; i < 93; i++) begin
            src[i] = (i == int'(hot)) ^ inv;
        end
        for (int i = 0; i < NUM_PINS; i++) begin
            pin_in[i] = pin_oe[i] ? pin_out[i] : ((i + 100 == int'(hot)) ^ inv);
        end
    end
endmodule : apr_far_model

// file: sim/apr_router_assertions.sv
`timescale 1ns/1ns
module apr_router_chk
    import apr_pkg::*;
(
    input wire logic                              sys_clk,
    input wire logic                              resetn,
    input wire logic [NUM_PINS*PIN_SEL_W-1:0]     pin_source_select,
    input wire logic [NUM_MISCA*MISC_SEL_W-1:0]   misc_routing_set_a,
    input wire logic [NUM_MISCB*MISC_SEL_W-1:0]   misc_routing_set_b,
    input wire logic [NUM_PINS*EN_SEL_W-1:0]      pin_drive_enable_select,
    input wire logic [NUM_CKG-1:0]                one_shot_enable,
    input wire logic [NUM_SPORTS-1:0]             serial_port_data_a_out,
    input wire logic [NUM_SPORTS-1:0]             serial_port_tx_valid_out,
    input wire logic [NUM_PINS-1:0]               pin_out,
    input wire logic [NUM_PINS-1:0]               pin_oe,
    input wire logic [NUM_PINS-1:0]               pin_buffer_output,
    input wire logic [NUM_MISCA-1:0]              misc_control_a_out,
    input wire logic [NUM_MISCB-1:0]              misc_control_b_out,
    input wire logic [NUM_CKG-1:0]                one_shot_trigger
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    AST_PIN_DATA: assert property (pin_source_select[6:0] == 7'h14
        |=> pin_out[0] == $past(serial_port_data_a_out[0])) else $error("pin data a wrong");
    AST_PIN_TDV: assert property (pin_source_select[6:0] == 7'h46
        |=> pin_out[0] == $past(serial_port_tx_valid_out[0])) else $error("pin tdv wrong");
    AST_PIN_RSV: assert property (pin_source_select[6:0] == 7'h3c |=> !pin_out[0])
        else $error("reserved pin code not low");
    AST_PIN_HIGH: assert property (pin_source_select[6:0] == 7'h7f |=> pin_out[0])
        else $error("pin high code not high");
    AST_EN_HIGH: assert property (pin_drive_enable_select[5:0] == 6'h01 |=> pin_oe[0])
        else $error("enable high code not high");
    AST_EN_RSV: assert property (pin_drive_enable_select[5:0] > 6'h19 |=> !pin_oe[0])
        else $error("reserved enable code not low");
    AST_DRIVEN: assert property (pin_oe[0] |=> pin_buffer_output[0] == $past(pin_out[0]))
        else $error("driven pin buffer differs from pin value");
    AST_MISC_HIGH: assert property (misc_routing_set_a[4:0] == 5'h1f
        ##0 misc_routing_set_b[4:0] == 5'h1f |=> misc_control_a_out[0] && misc_control_b_out[0])
        else $error("misc high code not high");
    AST_MISCB_LOW: assert property (misc_routing_set_b[9:5] == 5'h1e |=> !misc_control_b_out[1])
        else $error("misc b low code not low");
    AST_TRIG: assert property (one_shot_enable[0] |=> one_shot_trigger[0] == misc_control_a_out[2])
        else $error("trigger a differs from misc a2");
    AST_TRIG_OFF: assert property (!one_shot_enable[3] |=> !one_shot_trigger[3])
        else $error("trigger d without one-shot");
endmodule : apr_router_chk
bind apr_router apr_router_chk i_apr_router_chk (.sys_clk(sys_clk), .resetn(resetn),
    .pin_source_select(pin_source_select), .misc_routing_set_a(misc_routing_set_a),
    .misc_routing_set_b(misc_routing_set_b), .pin_drive_enable_select(pin_drive_enable_select),
    .one_shot_enable(one_shot_enable), .serial_port_data_a_out(serial_port_data_a_out),
    .serial_port_tx_valid_out(serial_port_tx_valid_out), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_buffer_output(pin_buffer_output), .misc_control_a_out(misc_control_a_out),
    .misc_control_b_out(misc_control_b_out), .one_shot_trigger(one_shot_trigger));

// file: sim/apr_router_bench.sv
`timescale 1ns/1ns
module apr_router_bench;
    import apr_pkg::*;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic [139:0] psel = '0;
    logic [29:0]  masel = '0;
    logic [9:0]   mbsel = '0;
    logic [119:0] ensel = '0;
    logic [19:0]  pinv = '0;
    logic [3:0]   ose = '0;
    logic [7:0]   hot = 8'hff;
    logic         inv = 1'b0;
    logic [92:0]  src;
    logic [19:0]  pin_in, pin_out, pin_oe, pbuf;
    logic [5:0]   ma_out;
    logic [1:0]   mb_out;
    logic [3:0]   trig;
    int n_errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    // source index per code; -1 low or reserved, -2 high, 100+ pin buffer
    int ptbl [36] = '{40, 41, -1, -1, 22, 23, 30, 31, 49, 50, 53, 54, -1, 57, 58, 59, 60, 43,
                      44, 45, 46, 42, 32, 33, 34, 35, 36, 37, 38, 39, 47, 48, 51, 52, 55, 56};
    int mtbl [12] = '{24, 25, 26, 27, 28, 29, 41, 53, 50, 54, -1, -2};
    always #25 sys_clk = ~sys_clk;
    apr_far_model i_apr_far_model (.hot(hot), .inv(inv), .pin_out(pin_out), .pin_oe(pin_oe),
        .src(src), .pin_in(pin_in));
    apr_router i_apr_router (.sys_clk(sys_clk), .resetn(resetn), .pin_source_select(psel),
        .misc_routing_set_a(masel), .misc_routing_set_b(mbsel), .pin_drive_enable_select(ensel),
        .pin_invert(pinv), .one_shot_enable(ose), .pin_in(pin_in),
        .serial_port_data_a_out(src[7:0]), .serial_port_data_b_out(src[15:8]),
        .serial_port_clock_out(src[23:16]), .serial_port_frame_sync_out(src[31:24]),
        .serial_port_tx_valid_out(src[39:32]), .serial_port_drive_en(src[92:61]),
        .parallel_port_request_strobe(src[40]), .spdif_tx_block_start(src[41]),
        .spdif_tx_biphase_out(src[42]), .spdif_rx_data_out(src[43]),
        .spdif_rx_frame_sync_out(src[44]), .spdif_rx_clock_out(src[45]),
        .spdif_rx_tdm_clock_out(src[46]), .spdif_rx_pll_reference(src[47]),
        .spdif_rx_pll_feedback(src[48]), .precision_clock_out(src[52:49]),
        .precision_frame_sync_out(src[56:53]), .rate_converter_data_out(src[60:57]),
        .pin_out(pin_out), .pin_oe(pin_oe), .pin_buffer_output(pbuf),
        .misc_control_a_out(ma_out), .misc_control_b_out(mb_out), .one_shot_trigger(trig));
    function automatic int pcode(int c);
        if (c <= 'h13) return 100 + c;
        if (c <= 'h1f) return (c - 'h14) / 2 + ((c - 'h14) % 2) * 8;
        if (c <= 'h2b) return 16 + c - 'h20 + ((c >= 'h26) ? 2 : 0);
        if (c <= 'h2f) return 6 + (c - 'h2c) / 2 + ((c - 'h2c) % 2) * 8;
        if (c <= 'h53) return ptbl[c - 'h30];
        return (c == 'h7f) ? -2 : -1;
    endfunction : pcode
    function automatic logic sval(int idx);
        if (idx < 0) return idx == -2;
        return (idx == int'(hot)) ^ inv ^ ((idx >= 100) ? pinv[idx - 100] : 1'b0);
    endfunction : sval
    task automatic check(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic apply(input int idx, input int p);
        hot <= (idx < 0) ? 8'hff : 8'(idx);
        inv <= p[0];
        repeat (5) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask : apply
    task automatic summarize();
        if (n_errors == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : summarize
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            summarize();
        end
    end
    initial begin
        logic [29:0] mv;
        int idx;
        repeat (5) @(posedge sys_clk);
        resetn <= 1'b1;
        for (int c = 0; c < 128; c++) begin
            for (int p = 0; p < 2; p++) begin
                @(posedge sys_clk);
                psel[6:0] <= c[6:0];
                apply(pcode(c), p);
                check(pin_out[0], sval(pcode(c)));
            end
        end
        for (int c = 0; c < 32; c++) begin
            for (int p = 0; p < 2; p++) begin
                @(posedge sys_clk);
                masel <= {6{c[4:0]}};
                mbsel <= {2{c[4:0]}};
                ose <= 4'h5;
                pinv <= 20'h00005;
                idx = (c <= 'h13) ? 100 + c : mtbl[c - 'h14];
                apply(idx, p);
                for (int k = 0; k < 6; k++) check(ma_out[k], sval(idx));
                for (int k = 0; k < 2; k++) check(mb_out[k], sval(idx));
                for (int k = 0; k < 4; k++) check(trig[k], ose[k] & sval(idx));
            end
        end
        for (int c = 0; c < 64; c++) begin
            for (int p = 0; p < 2; p++) begin
                @(posedge sys_clk);
                ensel[5:0] <= c[5:0];
                for (int k = 0; k < 6; k++) mv[5*k +: 5] = ((k == c - 2) ^ p[0]) ? 5'h1f : 5'h1e;
                masel <= mv;
                idx = (c <= 1) ? -1 - c : (c >= 8 && c <= 'h19) ? 53 + c : -1;
                apply(idx, p);
                if (c >= 2 && c <= 7) check(pin_oe[0], !p[0]);
                else check(pin_oe[0], sval(idx));
            end
        end
        @(posedge sys_clk);
        psel[13:7] <= 7'h7f;
        ensel[11:6] <= 6'h01;
        apply(-1, 0);
        check(pin_oe[1], 1'b1);
        check(pbuf[1], 1'b1);
        @(posedge sys_clk);
        ensel[11:6] <= 6'h00;
        apply(-1, 0);
        check(pbuf[1], 1'b0);
        summarize();
    end
endmodule : apr_router_bench
